/* verilog/tws_slave.sv */
`timescale 1ns/1ps
`default_nettype none

`include "tws_cfg.svh"

module tws_slave (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial bus
    tws_if.dev bus,
    // Pins
    input wire logic [2:0] address_strap_pins,
    input wire logic monitor_detect_pin,
    // User side
    input wire logic [7:0] status_in,
    output logic [15:0][7:0] cfg_regs,
    output logic wr_strobe,
    output logic [3:0] wr_addr,
    output logic [7:0] wr_data,
    output logic monitor_present
);
    import tws_pkg::*;

    // ----------------------------------------------------------------
    // State and reset value
    // ----------------------------------------------------------------
    localparam tws_dev_s DEV_RST = '{
        st: DS_IDLE,
        scl_sy: 2'h3,
        sda_sy: 2'h3,
        scl_d: 1'h1,
        sda_d: 1'h1,
        sda_oe_n: 1'h1,
        regs: {16{`TWS_REG_RESET}},
        default: '0
    };
    localparam logic [15:0] RO_MASK = `TWS_RO_MASK;

    tws_dev_s r;
    tws_dev_s n;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic byte_done;
    logic addr_match;
    logic [7:0] rd_byte;

    // ----------------------------------------------------------------
    // Bus event decode
    // ----------------------------------------------------------------
    // Edges seen on the second synchroniser stage only
    assign scl_rise = r.scl_sy[1] & ~r.scl_d;
    assign scl_fall = ~r.scl_sy[1] & r.scl_d;
    // Start: data falls while clock high
    assign start_cond = r.scl_sy[1] & r.scl_d & r.sda_d & ~r.sda_sy[1];
    // Stop: data rises while clock high
    assign stop_cond = r.scl_sy[1] & r.scl_d & ~r.sda_d & r.sda_sy[1];
    assign byte_done = scl_fall & (r.cnt == 4'h8);
    // Fixed upper bits plus strapped lower bits
    assign addr_match = (r.sh[7:1] == {`TWS_ADDR_HI, r.strap_sy[1]});

    // Read-only locations show live status and panel presence
    always_comb begin
        rd_byte = r.regs[r.ptr];
        if (RO_MASK[r.ptr]) begin
            rd_byte = status_in;
            rd_byte[`TWS_DET_BIT] = r.det_sy[1];
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        // Two-stage synchronisers on every pin
        n.scl_sy = {r.scl_sy[0], bus.scl};
        n.sda_sy = {r.sda_sy[0], bus.sda};
        n.det_sy = {r.det_sy[0], monitor_detect_pin};
        n.strap_sy = {r.strap_sy[0], address_strap_pins};
        n.scl_d = r.scl_sy[1];
        n.sda_d = r.sda_sy[1];
        n.wr_stb = 1'h0;
        n.sda_out = 1'h0;

        // Shift in receive bytes on clock rise
        if ((r.st == DS_ADDR || r.st == DS_REG || r.st == DS_WDATA)
            && scl_rise && r.cnt != 4'h8) begin
            n.sh = {r.sh[6:0], r.sda_sy[1]};
            n.cnt = r.cnt + 4'h1;
        end

        if (start_cond) begin
            // Start or repeated start re-arms address reception
            n.st = DS_ADDR;
            n.cnt = 4'h0;
            n.sda_oe_n = 1'h1;
        end else if (stop_cond) begin
            n.st = DS_IDLE;
            n.sda_oe_n = 1'h1;
        end else begin
            case (r.st)
                DS_ADDR: begin
                    if (byte_done) begin
                        n.cnt = 4'h0;
                        if (addr_match) begin
                            n.rw = r.sh[0];
                            n.sda_oe_n = 1'h0;
                            n.st = DS_ACK_ADDR;
                        end else begin
                            n.sda_oe_n = 1'h1;
                            n.st = DS_IDLE;
                        end
                    end
                end
                DS_ACK_ADDR: begin
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (r.rw == `TWS_DIR_READ) begin
                            // Put data MSB on the line right after the ack
                            n.sh = rd_byte;
                            n.sda_oe_n = rd_byte[7];
                            n.st = DS_RDATA;
                        end else begin
                            n.sda_oe_n = 1'h1;
                            n.st = DS_REG;
                        end
                    end
                end
                DS_REG: begin
                    if (byte_done) begin
                        n.cnt = 4'h0;
                        n.ptr = r.sh[3:0];
                        n.sda_oe_n = 1'h0;
                        n.st = DS_ACK_REG;
                    end
                end
                DS_ACK_REG: begin
                    if (scl_fall) begin
                        n.sda_oe_n = 1'h1;
                        n.st = DS_WDATA;
                    end
                end
                DS_WDATA: begin
                    if (byte_done) begin
                        n.cnt = 4'h0;
                        if (!RO_MASK[r.ptr]) begin
                            n.regs[r.ptr] = r.sh;
                        end
                        n.wr_stb = ~RO_MASK[r.ptr];
                        n.wr_addr = r.ptr;
                        n.wr_data = r.sh;
                        n.sda_oe_n = 1'h0;
                        n.st = DS_ACK_WDATA;
                    end
                end
                DS_ACK_WDATA: begin
                    if (scl_fall) begin
                        // No page mode: further bytes go unanswered
                        n.sda_oe_n = 1'h1;
                        n.st = DS_IDLE;
                    end
                end
                DS_RDATA: begin
                    if (scl_fall) begin
                        if (r.cnt == 4'h7) begin
                            n.sda_oe_n = 1'h1;
                            n.st = DS_RACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'h0};
                            n.sda_oe_n = r.sh[6];
                            n.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                DS_RACK: begin
                    // Either answer ends the single-byte read
                    if (scl_fall) begin
                        n.st = DS_IDLE;
                    end
                end
                default: begin
                    n.sda_oe_n = 1'h1;
                    if (r.st != DS_IDLE) begin
                        n.st = DS_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Everything is clocked by ref_clk; bus clock edges are only sampled, never used as a clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= DEV_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // All taken straight from state flops
    assign bus.s_sda_oe_n = r.sda_oe_n;
    assign bus.s_sda_out = r.sda_out;
    assign cfg_regs = r.regs;
    assign wr_strobe = r.wr_stb;
    assign wr_addr = r.wr_addr;
    assign wr_data = r.wr_data;
    assign monitor_present = r.det_sy[1];

endmodule

`default_nettype wire

/* verilog/tws_cfg.svh */
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// ----------------------------------------------------------------
// Slave addressing
// ----------------------------------------------------------------
`define TWS_ADDR_HI 4'h7
`define TWS_DIR_WRITE 1'h0
`define TWS_DIR_READ 1'h1

// ----------------------------------------------------------------
// Register file
// ----------------------------------------------------------------
`define TWS_REG_RESET 8'h00
`define TWS_RO_MASK 16'h00F0
`define TWS_DET_BIT 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TWS_CLK_PERIOD_NS 5
`define TWS_SCL_PERIOD_NS 2500
`define TWS_QUARTER_CYCLES ((`TWS_SCL_PERIOD_NS + 4 * `TWS_CLK_PERIOD_NS - 1) / (4 * `TWS_CLK_PERIOD_NS))

`endif

/* verilog/tws_pkg.sv */
`default_nettype none

package tws_pkg;

    // ----------------------------------------------------------------
    // Slave states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [8:0] {
        DS_IDLE = 9'h001,
        DS_ADDR = 9'h002,
        DS_ACK_ADDR = 9'h004,
        DS_REG = 9'h008,
        DS_ACK_REG = 9'h010,
        DS_WDATA = 9'h020,
        DS_ACK_WDATA = 9'h040,
        DS_RDATA = 9'h080,
        DS_RACK = 9'h100
    } tws_dev_st_e;

    // ----------------------------------------------------------------
    // Master states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_START = 5'h02,
        HS_TX = 5'h04,
        HS_RX = 5'h08,
        HS_STOP = 5'h10
    } tws_host_st_e;

    // ----------------------------------------------------------------
    // Master commands
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_WRITE = 2'h0,
        CMD_READ_SET = 2'h1,
        CMD_READ_CUR = 2'h2
    } tws_cmd_e;

    // Slave state
    typedef struct packed {
        tws_dev_st_e st;
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic [1:0] det_sy;
        logic [1:0][2:0] strap_sy;
        logic scl_d;
        logic sda_d;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic [3:0] ptr;
        logic [15:0][7:0] regs;
        logic sda_oe_n;
        logic sda_out;
        logic wr_stb;
        logic [3:0] wr_addr;
        logic [7:0] wr_data;
    } tws_dev_s;

    // Master state
    typedef struct packed {
        tws_host_st_e st;
        tws_cmd_e kind;
        logic [2:0] step;
        logic [15:0] qcnt;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] rxb;
        logic [6:0] dev_addr;
        logic [7:0] reg_addr;
        logic [7:0] wdata;
        logic [1:0] sda_sy;
        logic scl_oe_n;
        logic sda_oe_n;
        logic ready;
        logic done;
        logic [7:0] rdata;
        logic nack;
    } tws_host_s;

endpackage

`default_nettype wire

/* verilog/tws_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tws_if;
    // Master drivers
    logic m_scl_oe_n;
    logic m_scl_out;
    logic m_sda_oe_n;
    logic m_sda_out;
    // Slave drivers
    logic s_sda_oe_n;
    logic s_sda_out;
    // Resolved wire levels, pulled up when released
    logic scl;
    logic sda;

    // Open-drain resolution: a driven low wins
    assign scl = ~(~m_scl_oe_n & ~m_scl_out);
    assign sda = ~((~m_sda_oe_n & ~m_sda_out) | (~s_sda_oe_n & ~s_sda_out));

    modport dev (input scl, input sda, output s_sda_oe_n, output s_sda_out);
    modport host (input scl, input sda, output m_scl_oe_n, output m_scl_out,
                  output m_sda_oe_n, output m_sda_out);
endinterface

`default_nettype wire

/* verilog/tws_master.sv */
`timescale 1ns/1ps
`default_nettype none

`include "tws_cfg.svh"

module tws_master #(
    parameter int unsigned QUARTER = `TWS_QUARTER_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial bus
    tws_if.host bus,
    // Command port
    input wire logic cmd_valid,
    input wire tws_pkg::tws_cmd_e cmd_kind,
    input wire logic [6:0] cmd_dev_addr,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_wdata,
    // Answer port
    output logic cmd_ready,
    output logic done,
    output logic [7:0] rdata,
    output logic nack
);
    import tws_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    localparam tws_host_s HOST_RST = '{
        st: HS_IDLE,
        kind: CMD_WRITE,
        sda_sy: 2'h3,
        scl_oe_n: 1'h1,
        sda_oe_n: 1'h1,
        default: '0
    };

    tws_host_s r;
    tws_host_s n;
    logic tick;

    // Segment order of each transfer
    function automatic tws_host_st_e seg_state(tws_cmd_e k, logic [2:0] s);
        tws_host_st_e res;
        res = HS_STOP;
        case (k)
            CMD_WRITE: res = (s == 3'h0) ? HS_START : (s <= 3'h3) ? HS_TX : HS_STOP;
            CMD_READ_SET: begin
                case (s)
                    3'h0, 3'h3: res = HS_START;
                    3'h1, 3'h2, 3'h4: res = HS_TX;
                    3'h5: res = HS_RX;
                    default: res = HS_STOP;
                endcase
            end
            CMD_READ_CUR: begin
                case (s)
                    3'h0: res = HS_START;
                    3'h1: res = HS_TX;
                    3'h2: res = HS_RX;
                    default: res = HS_STOP;
                endcase
            end
            default: res = HS_STOP;
        endcase
        return res;
    endfunction

    // Byte sent in each transmit segment
    function automatic logic [7:0] seg_byte(tws_cmd_e k, logic [2:0] s, logic [6:0] da,
                                            logic [7:0] rg, logic [7:0] wd);
        logic [7:0] b;
        b = 8'h00;
        if (s == 3'h1) begin
            b = {da, (k == CMD_READ_CUR) ? `TWS_DIR_READ : `TWS_DIR_WRITE};
        end else if (s == 3'h2) begin
            b = rg;
        end else if (s == 3'h3) begin
            b = wd;
        end else if (s == 3'h4) begin
            b = {da, `TWS_DIR_READ};
        end
        return b;
    endfunction

    assign tick = (r.qcnt == 16'(QUARTER - 1));

    // ----------------------------------------------------------------
    // Next-state logic: four quarter phases per bit slot
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        n.sda_sy = {r.sda_sy[0], bus.sda};
        n.done = 1'h0;
        if (r.st == HS_IDLE) begin
            n.qcnt = 16'h0000;
            n.ready = 1'h1;
            if (cmd_valid && r.ready) begin
                n.ready = 1'h0;
                n.kind = cmd_kind;
                n.dev_addr = cmd_dev_addr;
                n.reg_addr = cmd_reg;
                n.wdata = cmd_wdata;
                n.nack = 1'h0;
                n.step = 3'h0;
                n.ph = 2'h0;
                n.st = HS_START;
            end
        end else begin
            n.qcnt = tick ? 16'h0000 : r.qcnt + 16'h0001;
            if (tick) begin
                n.ph = r.ph + 2'h1;
                case (r.st)
                    HS_START: begin
                        case (r.ph)
                            2'h0: n.sda_oe_n = 1'h1;
                            2'h1: n.scl_oe_n = 1'h1;
                            2'h2: n.sda_oe_n = 1'h0;
                            default: n.scl_oe_n = 1'h0;
                        endcase
                    end
                    HS_TX, HS_RX: begin
                        case (r.ph)
                            2'h0: begin
                                if (r.st == HS_TX) begin
                                    n.sda_oe_n = (r.bitn == 4'h8) ? 1'h1 : r.sh[7];
                                end else begin
                                    // Acknowledge the returned byte
                                    n.sda_oe_n = (r.bitn != 4'h8);
                                end
                            end
                            2'h1: n.scl_oe_n = 1'h1;
                            2'h2: begin
                                if (r.st == HS_TX && r.bitn == 4'h8) begin
                                    n.nack = r.sda_sy[1];
                                end else if (r.st == HS_RX && r.bitn != 4'h8) begin
                                    n.rxb = {r.rxb[6:0], r.sda_sy[1]};
                                end
                            end
                            default: begin
                                n.scl_oe_n = 1'h0;
                                n.bitn = r.bitn + 4'h1;
                                n.sh = {r.sh[6:0], 1'h0};
                                if (r.st == HS_RX && r.bitn == 4'h8) begin
                                    n.rdata = r.rxb;
                                end
                            end
                        endcase
                    end
                    HS_STOP: begin
                        case (r.ph)
                            2'h0: n.sda_oe_n = 1'h0;
                            2'h1: n.scl_oe_n = 1'h1;
                            2'h2: n.sda_oe_n = 1'h1;
                            default: begin
                                n.st = HS_IDLE;
                                n.ready = 1'h1;
                                n.done = 1'h1;
                            end
                        endcase
                    end
                    default: n.st = HS_IDLE;
                endcase
                // Segment end: move to the next, or stop on a refused byte
                if (r.ph == 2'h3 && (r.st == HS_START
                    || ((r.st == HS_TX || r.st == HS_RX) && r.bitn == 4'h8))) begin
                    n.step = r.step + 3'h1;
                    n.bitn = 4'h0;
                    n.st = r.nack ? HS_STOP : seg_state(r.kind, n.step);
                    n.sh = seg_byte(r.kind, n.step, r.dev_addr, r.reg_addr, r.wdata);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= HOST_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign bus.m_scl_oe_n = r.scl_oe_n;
    assign bus.m_scl_out = 1'h0;
    assign bus.m_sda_oe_n = r.sda_oe_n;
    assign bus.m_sda_out = 1'h0;
    assign cmd_ready = r.ready;
    assign done = r.done;
    assign rdata = r.rdata;
    assign nack = r.nack;

endmodule

`default_nettype wire

/* verif/tws_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module tws_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Interface signals
    input wire logic m_scl_oe_n,
    input wire logic m_sda_oe_n,
    input wire logic s_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    // ------------------------------------------------------------
    // Bus edge tracking
    // ------------------------------------------------------------
    logic scl_d_r;
    logic sda_d_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic rise_w;
    logic start_w;

    // Clock rise and start condition seen on the wire
    assign rise_w = scl & ~scl_d_r;
    assign start_w = scl & scl_d_r & sda_d_r & ~sda;

    // Count clock rises since start and collect the first byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
        end else begin
            scl_d_r <= scl;
            sda_d_r <= sda;
            if (start_w) begin
                cnt_r <= 4'h0;
            end else if (rise_w && cnt_r != 4'hF) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (rise_w && cnt_r < 4'h8) begin
                sh_r <= {sh_r[6:0], sda};
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_reset_released: assert property ($fell(rst) |-> m_scl_oe_n && m_sda_oe_n && s_sda_oe_n)
        else $error("line driven right after reset");
    chk_slave_pull_low: assert property ($fell(s_sda_oe_n) |-> !scl)
        else $error("slave pulled data while clock high");
    chk_no_contention: assert property (scl && !s_sda_oe_n |-> m_sda_oe_n)
        else $error("master and slave drive data together");
    chk_ack_held_high: assert property (rise_w && !s_sda_oe_n |=> (!s_sda_oe_n)[*4])
        else $error("slave bit not held over clock high");
    chk_clock_low_width: assert property ($fell(scl) |=> (!scl)[*3])
        else $error("clock low phase too short");
    chk_ack_after_eight: assert property ($fell(s_sda_oe_n) && cnt_r < 4'h9 |-> cnt_r == 4'h8)
        else $error("address acknowledge not after eight bits");
    chk_addr_high_bits: assert property (rise_w && cnt_r == 4'h8 && !s_sda_oe_n |-> sh_r[7:4] == 4'h7)
        else $error("acknowledge given to foreign address");
    chk_data_stable_high: assert property (scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe_n))
        else $error("data changed under clock high");

    // Main scenarios reached
    cov_addr_ack: cover property (rise_w && cnt_r == 4'h8 && !s_sda_oe_n);
    cov_read_bit: cover property (rise_w && cnt_r > 4'h8 && !s_sda_oe_n && m_sda_oe_n);
    cov_start: cover property (start_w);
endmodule

`default_nettype wire

/* verif/two_wire_register_slave_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module two_wire_register_slave_tb_top;
    import tws_pkg::*;
    typedef struct packed {
        logic rd;
        logic nack;
        logic [7:0] data;
    } tws_note_s;
    logic ref_clk, rst, cmd_valid, cmd_ready, done, nack, wr_strobe, det, present;
    tws_cmd_e cmd_kind;
    logic [6:0] cmd_dev;
    logic [7:0] cmd_reg, cmd_wdata, rdata, wr_data, status_in, d;
    logic [2:0] strap;
    logic [3:0] wr_addr, r;
    logic [15:0][7:0] cfg_regs;
    tws_note_s cq[$];
    tws_note_s mn;
    logic [11:0] wq[$];
    logic [11:0] mw;
    integer n_errors, checks, seed, i;

    // ------------------------------------------------------------
    // Both ends joined by one interface
    // ------------------------------------------------------------
    tws_if bus_if();
    tws_master #(.QUARTER(4)) u_tws_master (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.host),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_dev_addr(cmd_dev), .cmd_reg(cmd_reg),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done), .rdata(rdata), .nack(nack));
    tws_slave u_tws_slave (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.dev),
        .address_strap_pins(strap), .monitor_detect_pin(det), .status_in(status_in),
        .cfg_regs(cfg_regs), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
        .monitor_present(present));
    tws_chk u_chk (.ref_clk(ref_clk), .rst(rst), .m_scl_oe_n(bus_if.m_scl_oe_n),
        .m_sda_oe_n(bus_if.m_sda_oe_n), .s_sda_oe_n(bus_if.s_sda_oe_n), .scl(bus_if.scl),
        .sda(bus_if.sda));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Compare, wait and command tasks
    // ------------------------------------------------------------
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks = checks + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp1(input string nm, input logic e, input logic g);
        checks = checks + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_ready();
        integer t;
        t = 0;
        while (cmd_ready !== 1'b1 && t < 3000) begin
            @(negedge ref_clk);
            t = t + 1;
        end
        if (t >= 3000) begin
            n_errors = n_errors + 1;
            $display("ERROR cmd_ready expected 1 seen timeout");
            finish_test();
        end
    endtask

    task automatic run(input tws_cmd_e k, input logic [6:0] a, input logic [7:0] rg,
                       input logic [7:0] wd, input tws_note_s nt);
        wait_ready();
        cmd_kind = k;
        cmd_dev = a;
        cmd_reg = rg;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        cq.push_back(nt);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        wait_ready();
    endtask

    // Result watcher: oldest note against each answer
    always @(posedge ref_clk) begin
        if (done === 1'b1) begin
            // An answer with no note left is checked against nack 1 and rdata FF
            mn = (cq.size() > 0) ? cq.pop_front() : 10'h3FF;
            cmp1("nack", mn.nack, nack);
            if (mn.rd) begin
                cmp8("rdata", mn.data, rdata);
            end
        end
        if (wr_strobe === 1'b1) begin
            mw = wq.size() > 0 ? wq.pop_front() : 12'hFFF;
            cmp8("wr_addr", {4'h0, mw[11:8]}, {4'h0, wr_addr});
            cmp8("wr_data", mw[7:0], wr_data);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 73886;
        n_errors = 0;
        checks = 0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_kind = CMD_WRITE;
        cmd_dev = 7'h00;
        cmd_reg = 8'h00;
        cmd_wdata = 8'h00;
        strap = 3'($random(seed));
        det = 1'b1;
        status_in = 8'($random(seed));
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        repeat (5) @(negedge ref_clk);
        // Writes to read/write places, then both read forms
        for (i = 0; i < 4; i = i + 1) begin
            r = 4'($random(seed));
            if (r[3:2] == 2'b01) begin
                r[3] = 1'b1;
            end
            d = 8'($random(seed));
            wq.push_back({r, d});
            run(CMD_WRITE, {4'h7, strap}, {d[7:4], r}, d, '{1'b0, 1'b0, d});
            cmp8("cfg_regs", d, cfg_regs[r]);
            run(CMD_READ_SET, {4'h7, strap}, {4'h0, r}, 8'h00, '{1'b1, 1'b0, d});
            run(CMD_READ_CUR, {4'h7, strap}, 8'h00, 8'h00, '{1'b1, 1'b0, d});
        end
        $display("test write and read done");
        // Read-only place: write dropped, read shows status and detect level
        for (i = 0; i < 2; i = i + 1) begin
            det = i[0];
            repeat (4) @(negedge ref_clk);
            cmp1("monitor_present", det, present);
            d = {status_in[7:1], det};
            run(CMD_WRITE, {4'h7, strap}, 8'h05, ~status_in, '{1'b0, 1'b0, 8'h00});
            cmp8("cfg_regs", 8'h00, cfg_regs[5]);
            run(CMD_READ_SET, {4'h7, strap}, 8'h05, 8'h00, '{1'b1, 1'b0, d});
            run(CMD_READ_CUR, {4'h7, strap}, 8'h00, 8'h00, '{1'b1, 1'b0, d});
        end
        $display("test read-only done");
        // Foreign addresses get no acknowledge
        run(CMD_WRITE, {4'h3, strap}, 8'h01, 8'hA5, '{1'b0, 1'b1, 8'h00});
        run(CMD_READ_CUR, {4'h7, ~strap}, 8'h00, 8'h00, '{1'b0, 1'b1, 8'h00});
        // Let the watcher take the last answer before the verdict
        repeat (4) @(negedge ref_clk);
        cmp1("notes_drained", 1'b1, cq.size() == 0 && wq.size() == 0);
        $display("test foreign address done");
        finish_test();
    end
endmodule

`default_nettype wire
